// ===== port_power_defs.svh
// Constants for the port power and overcurrent sense block
// Function
// R1 - While a port is powered, sample its control and sense pin every cycle.
// R2 - Flag overcurrent on a long low run or two low groups within window.
// R3 - Pulse width: 4-bit field, 0..15 ms, default 5; upper bits read zero.
// R4 - 8-bit window in 1 ms steps; a second low inside it flags overcurrent.
// R5 - Double-pulse window resets to twenty milliseconds.
// R6 - After power is switched on, ignore the pin until lockout time passes.
// R7 - Lockout time is 8 bits in 1 ms steps, resetting to ten milliseconds.
// R8 - Remove port power by actively driving the pin low.
// R9 - Apply port power by releasing the driver and enabling the pull-up; the block only releases the driver and has no pull-up enable.
// R10 - A released pin reading low means the fuse opened: overcurrent.
// R11 - Fuse setups keep one combined control and sense pin per port.
// R12 - With poly fuses, software sets power-good descriptor times to zero.
// R13 - Lockout restarts at every power-on; lockout samples never count.
// R14 - Latch a per-port overcurrent flag and report it to hub status.
`ifndef PORT_POWER_DEFS_SVH
`define PORT_POWER_DEFS_SVH

`define OFS_LOCKOUT_TIME   16'h30E1
`define OFS_MIN_PULSE      16'h30EA
`define OFS_DOUBLE_WINDOW  16'h30EB

`define RST_LOCKOUT_TIME   8'h0A
`define RST_MIN_PULSE      4'h5
`define RST_DOUBLE_WINDOW  8'h14

`define MIN_PULSE_MSB      3
`define CLK_PERIOD_PS      4000
`define ONE_MS_PS          1000000000
`define MS_CYCLES          (`ONE_MS_PS / `CLK_PERIOD_PS)

`endif

// ===== port_power_overcurrent_sense.sv
// Per-port power control and overcurrent sense filter
`timescale 1ns/1ps
`default_nettype none
`include "port_power_defs.svh"
module port_power_overcurrent_sense #(
	parameter int NUM_PORTS    = 6,
	parameter int CYCLES_PER_MS = `MS_CYCLES
) (
	// Clock and reset
	input  wire logic                 clk_sys_in,
	input  wire logic                 resetn_in,
	// Register access
	input  wire logic [15:0]          reg_addr_in,
	input  wire logic                 reg_wr_in,
	input  wire logic                 reg_rd_in,
	input  wire logic [7:0]           reg_wdata_in,
	output logic      [7:0]           reg_rdata_out,
	// Hub port control and status
	input  wire logic [NUM_PORTS-1:0] port_power_on_in,
	input  wire logic [NUM_PORTS-1:0] oc_flag_clear_in,
	output logic      [NUM_PORTS-1:0] oc_flag_out,
	// Shared control and sense pins, one per port
	input  wire logic [NUM_PORTS-1:0] port_power_sense_pin_in,
	output logic      [NUM_PORTS-1:0] port_power_sense_pin_out,
	output logic      [NUM_PORTS-1:0] port_power_sense_pin_oe_n_out
);
	localparam int MSW = $clog2(CYCLES_PER_MS);

	logic [7:0]                   lockout_time;
	logic [`MIN_PULSE_MSB:0]      min_pulse;
	logic [7:0]                   double_window;
	logic [7:0]                   next_lockout_time;
	logic [`MIN_PULSE_MSB:0]      next_min_pulse;
	logic [7:0]                   next_double_window;
	logic [7:0]                   next_rdata;

	always_comb begin
		next_lockout_time  = lockout_time;
		next_min_pulse     = min_pulse;
		next_double_window = double_window;
		next_rdata         = reg_rdata_out;
		if (reg_wr_in) begin
			if (reg_addr_in == `OFS_LOCKOUT_TIME) begin
				next_lockout_time = reg_wdata_in; // [R7]
			end else if (reg_addr_in == `OFS_MIN_PULSE) begin
				next_min_pulse = reg_wdata_in[`MIN_PULSE_MSB:0]; // [R3]
			end else if (reg_addr_in == `OFS_DOUBLE_WINDOW) begin
				next_double_window = reg_wdata_in; // [R4]
			end
		end
		if (reg_rd_in) begin
			if (reg_addr_in == `OFS_LOCKOUT_TIME) begin
				next_rdata = lockout_time;
			end else if (reg_addr_in == `OFS_MIN_PULSE) begin
				next_rdata = {4'h0, min_pulse}; // [R3]
			end else if (reg_addr_in == `OFS_DOUBLE_WINDOW) begin
				next_rdata = double_window;
			end else begin
				next_rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			lockout_time  <= `RST_LOCKOUT_TIME; // [R7]
			min_pulse     <= `RST_MIN_PULSE; // [R3]
			double_window <= `RST_DOUBLE_WINDOW; // [R5]
			reg_rdata_out <= 8'h00;
		end else begin
			lockout_time  <= next_lockout_time;
			min_pulse     <= next_min_pulse;
			double_window <= next_double_window;
			reg_rdata_out <= next_rdata;
		end
	end

	// Shared millisecond tick; filters count whole ticks, so a run is
	// measured to within one millisecond of its true start.
	logic [MSW-1:0] ms_cnt;
	logic [MSW-1:0] next_ms_cnt;
	logic           ms_tick;
	logic           next_ms_tick;

	always_comb begin
		next_ms_tick = (ms_cnt == MSW'(CYCLES_PER_MS - 1));
		next_ms_cnt  = next_ms_tick ? '0 : ms_cnt + MSW'(1);
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ms_cnt  <= '0;
			ms_tick <= 1'b0;
		end else begin
			ms_cnt  <= next_ms_cnt;
			ms_tick <= next_ms_tick;
		end
	end

	port_power_pkg::sense_state_t state      [NUM_PORTS];
	port_power_pkg::sense_state_t next_state [NUM_PORTS];
	logic [7:0]                   cnt        [NUM_PORTS];
	logic [7:0]                   next_cnt   [NUM_PORTS];
	logic [NUM_PORTS-1:0]         detect;
	logic [NUM_PORTS-1:0]         next_flag;
	logic [NUM_PORTS-1:0]         next_oe_n;

	function automatic logic [7:0] bump(input logic [7:0] v, input logic t);
		bump = (t && v != 8'hFF) ? v + 8'h01 : v;
	endfunction

	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			next_state[p] = state[p];
			next_cnt[p]   = cnt[p];
			detect[p]     = 1'b0;
			next_oe_n[p]  = port_power_on_in[p]; // [R8] [R9] [R11]
			if (!port_power_on_in[p]) begin
				next_state[p] = port_power_pkg::ST_OFF;
				next_cnt[p]   = 8'h00;
			end else begin
				case (state[p])
				port_power_pkg::ST_OFF: begin
					next_state[p] = port_power_pkg::ST_LOCKOUT; // [R13]
					next_cnt[p]   = 8'h00;
				end
				port_power_pkg::ST_LOCKOUT: begin
					// Pin ignored here: slow ramps would look like faults
					next_cnt[p] = bump(cnt[p], ms_tick); // [R6]
					if (cnt[p] >= lockout_time) begin
						next_state[p] = port_power_pkg::ST_HIGH;
						next_cnt[p]   = 8'h00;
					end
				end
				port_power_pkg::ST_HIGH: begin
					if (!port_power_sense_pin_in[p]) begin // [R1] [R10]
						next_state[p] = port_power_pkg::ST_LOW;
						next_cnt[p]   = 8'h00;
						detect[p]     = (min_pulse == 4'h0); // [R2]
					end
				end
				port_power_pkg::ST_LOW: begin
					next_cnt[p] = bump(cnt[p], ms_tick);
					if (port_power_sense_pin_in[p]) begin
						next_state[p] = port_power_pkg::ST_GAP;
						next_cnt[p]   = 8'h00;
					end else if (cnt[p] >= {4'h0, min_pulse}) begin
						detect[p]     = 1'b1; // [R2] [R3]
						next_state[p] = port_power_pkg::ST_HIGH;
						next_cnt[p]   = 8'h00;
					end
				end
				port_power_pkg::ST_GAP: begin
					next_cnt[p] = bump(cnt[p], ms_tick);
					if (!port_power_sense_pin_in[p]) begin
						detect[p]     = 1'b1; // [R2] [R4]
						next_state[p] = port_power_pkg::ST_HIGH;
						next_cnt[p]   = 8'h00;
					end else if (cnt[p] >= double_window) begin
						next_state[p] = port_power_pkg::ST_HIGH;
						next_cnt[p]   = 8'h00;
					end
				end
				default: begin
					next_state[p] = port_power_pkg::ST_OFF;
				end
				endcase
			end
			// A detection in the clearing cycle wins over the clear
			next_flag[p] = detect[p] ||
				(oc_flag_out[p] && !oc_flag_clear_in[p]); // [R14]
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				state[p] <= port_power_pkg::ST_OFF;
				cnt[p]   <= 8'h00;
			end
			oc_flag_out                   <= '0;
			port_power_sense_pin_out      <= '0;
			port_power_sense_pin_oe_n_out <= '0;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				state[p] <= next_state[p];
				cnt[p]   <= next_cnt[p];
			end
			oc_flag_out                   <= next_flag;
			port_power_sense_pin_out      <= '0; // [R8]
			port_power_sense_pin_oe_n_out <= next_oe_n;
		end
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!resetn_in);

	sequence first_pulse_s;
		state[0] == port_power_pkg::ST_LOW && port_power_sense_pin_in[0]
		&& port_power_on_in[0];
	endsequence

	sequence second_low_s;
		state[0] == port_power_pkg::ST_GAP && !port_power_sense_pin_in[0]
		&& port_power_on_in[0];
	endsequence

	power_off_drive_a: assert property ( // [R8]
		!port_power_on_in[0] |=> !port_power_sense_pin_oe_n_out[0]
		&& !port_power_sense_pin_out[0])
		else $error("pin not driven low while power off");

	power_on_release_a: assert property ( // [R9]
		port_power_on_in[0] |=> port_power_sense_pin_oe_n_out[0])
		else $error("pin not released while power on");

	lockout_restart_a: assert property ( // [R13]
		$rose(port_power_on_in[0])
		|=> state[0] == port_power_pkg::ST_LOCKOUT && cnt[0] == 8'h00)
		else $error("lockout did not restart at power on");

	lockout_ignore_a: assert property ( // [R6]
		state[0] == port_power_pkg::ST_LOCKOUT && !oc_flag_out[0]
		|=> !oc_flag_out[0])
		else $error("flag set during lockout");

	single_detect_a: assert property ( // [R2]
		state[0] == port_power_pkg::ST_LOW && !port_power_sense_pin_in[0]
		&& port_power_on_in[0] && cnt[0] >= {4'h0, min_pulse}
		|=> oc_flag_out[0])
		else $error("long low run not flagged");

	double_detect_a: assert property ( // [R4]
		first_pulse_s ##[1:8] second_low_s |=> oc_flag_out[0])
		else $error("second low in window not flagged");

	flag_hold_a: assert property ( // [R14]
		oc_flag_out[0] && !oc_flag_clear_in[0] |=> oc_flag_out[0])
		else $error("flag lost without clear");

	sample_power_a: assert property ( // [R1]
		state[0] != port_power_pkg::ST_OFF |-> $past(port_power_on_in[0]))
		else $error("sampling while port unpowered");

	min_pulse_wr_a: assert property ( // [R3]
		reg_wr_in && reg_addr_in == `OFS_MIN_PULSE
		|=> min_pulse == $past(reg_wdata_in[3:0]))
		else $error("minimum width write not taken");

	window_wr_a: assert property ( // [R4]
		reg_wr_in && reg_addr_in == `OFS_DOUBLE_WINDOW
		|=> double_window == $past(reg_wdata_in))
		else $error("window write not taken");
endmodule
`default_nettype wire

// ===== port_power_overcurrent_sense_tb_top.sv
// Self-checking bench for the port power and overcurrent sense block
`timescale 1ns/1ps
`default_nettype none
module port_power_overcurrent_sense_tb_top;
	localparam int NP = 6;
	logic          clk_sys_in = 1'b0;
	logic          resetn_in = 1'b0;
	logic [15:0]   reg_addr_in = 16'h0000;
	logic          reg_wr_in = 1'b0;
	logic          reg_rd_in = 1'b0;
	logic [7:0]    reg_wdata_in = 8'h00;
	logic [7:0]    reg_rdata_out;
	logic [NP-1:0] power_on = '0;
	logic [NP-1:0] flag_clear = '0;
	logic [NP-1:0] oc_flag_out;
	logic [NP-1:0] pin_level;
	logic [NP-1:0] pin_drive;
	logic [NP-1:0] pin_oe_n;
	logic [NP-1:0] fault = '0;
	int            failures = 0;
	int            checked = 0;

	always #2 clk_sys_in = ~clk_sys_in;

	port_power_overcurrent_sense #(.NUM_PORTS(NP), .CYCLES_PER_MS(10)) u_dut (
		.clk_sys_in                    (clk_sys_in),
		.resetn_in                     (resetn_in),
		.reg_addr_in                   (reg_addr_in),
		.reg_wr_in                     (reg_wr_in),
		.reg_rd_in                     (reg_rd_in),
		.reg_wdata_in                  (reg_wdata_in),
		.reg_rdata_out                 (reg_rdata_out),
		.port_power_on_in              (power_on),
		.oc_flag_clear_in              (flag_clear),
		.oc_flag_out                   (oc_flag_out),
		.port_power_sense_pin_in       (pin_level),
		.port_power_sense_pin_out      (pin_drive),
		.port_power_sense_pin_oe_n_out (pin_oe_n)
	);

	port_power_partner #(.NUM_PORTS(NP)) u_partner (
		.pin_drive_in  (pin_drive),
		.pin_oe_n_in   (pin_oe_n),
		.fault_in      (fault),
		.pin_level_out (pin_level)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask

	task automatic reg_access(input logic wr, input logic [15:0] a,
		input logic [7:0] d);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = wr;
		reg_rd_in = !wr;
		cyc(1);
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		// Idle cycle so back-to-back calls never re-raise a strobe at once
		cyc(1);
	endtask

	task automatic test_reset_values();
		check({2'b00, pin_oe_n}, 8'h00);
		check({2'b00, oc_flag_out}, 8'h00);
		reg_access(1'b0, 16'h30E1, 8'h00);
		check(reg_rdata_out, 8'h0A);
		reg_access(1'b0, 16'h30EA, 8'h00);
		check(reg_rdata_out, 8'h05);
		reg_access(1'b0, 16'h30EB, 8'h00);
		check(reg_rdata_out, 8'h14);
		reg_access(1'b1, 16'h30E2, 8'hAA);
		reg_access(1'b0, 16'h30E2, 8'h00);
		check(reg_rdata_out, 8'h00);
	endtask

	task automatic test_programming();
		reg_access(1'b1, 16'h30EA, 8'hFF);
		reg_access(1'b0, 16'h30EA, 8'h00);
		check(reg_rdata_out, 8'h0F);
		reg_access(1'b1, 16'h30EA, 8'h02);
		reg_access(1'b1, 16'h30E1, 8'h02);
		reg_access(1'b1, 16'h30EB, 8'h03);
		reg_access(1'b0, 16'h30EB, 8'h00);
		check(reg_rdata_out, 8'h03);
	endtask

	task automatic test_lockout_and_single();
		power_on = 6'h03;
		cyc(1);
		check({2'b00, pin_oe_n}, 8'h03);
		// A double pulse inside lockout would flag if it were not ignored
		fault = 6'h01;
		cyc(2);
		fault = 6'h00;
		cyc(1);
		fault = 6'h01;
		cyc(2);
		fault = 6'h00;
		cyc(40);
		check({2'b00, oc_flag_out}, 8'h00);
		fault = 6'h02;
		cyc(8);
		check({2'b00, oc_flag_out}, 8'h00);
		cyc(32);
		check({2'b00, oc_flag_out}, 8'h02);
		fault = 6'h00;
		flag_clear = 6'h02;
		cyc(1);
		flag_clear = 6'h00;
		cyc(1);
		check({2'b00, oc_flag_out}, 8'h00);
	endtask

	task automatic test_double_pulse();
		reg_access(1'b1, 16'h30EA, 8'h05);
		fault = 6'h01;
		cyc(2);
		fault = 6'h00;
		cyc(100);
		check({2'b00, oc_flag_out}, 8'h00);
		fault = 6'h01;
		cyc(2);
		fault = 6'h00;
		cyc(5);
		fault = 6'h01;
		cyc(2);
		fault = 6'h00;
		cyc(2);
		check({2'b00, oc_flag_out}, 8'h01);
	endtask

	task automatic test_power_cycle();
		power_on = 6'h00;
		flag_clear = 6'h01;
		cyc(1);
		flag_clear = 6'h00;
		cyc(1);
		check({2'b00, pin_oe_n}, 8'h00);
		check({2'b00, pin_drive}, 8'h00);
		check({2'b00, oc_flag_out}, 8'h00);
		power_on = 6'h01;
		cyc(2);
		// Flag is clear first, so any lockout leak shows up below
		fault = 6'h01;
		cyc(2);
		fault = 6'h00;
		cyc(1);
		fault = 6'h01;
		cyc(2);
		fault = 6'h00;
		cyc(40);
		check({2'b00, oc_flag_out}, 8'h00);
	endtask

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		cyc(4);
		resetn_in = 1'b1;
		cyc(1);
		test_reset_values();
		test_programming();
		test_lockout_and_single();
		test_double_pulse();
		test_power_cycle();
		conclude();
	end

	// Whole sequence is well under a thousand cycles
	initial begin
		#20000;
		failures++;
		conclude();
	end
endmodule
`default_nettype wire

// ===== port_power_partner.sv
// External power switch or poly fuse model facing each port pin
`timescale 1ns/1ps
`default_nettype none
module port_power_partner #(
	parameter int NUM_PORTS = 6
) (
	// Device side of the shared pins
	input  wire logic [NUM_PORTS-1:0] pin_drive_in,
	input  wire logic [NUM_PORTS-1:0] pin_oe_n_in,
	// Fault injected per port by the bench
	input  wire logic [NUM_PORTS-1:0] fault_in,
	// Resolved wire level
	output logic      [NUM_PORTS-1:0] pin_level_out
);
	// A driven pin wins; a released pin rests on the pull-up unless the
	// switch flag or an open fuse pulls it low
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (!pin_oe_n_in[p]) begin
				pin_level_out[p] = pin_drive_in[p];
			end else begin
				pin_level_out[p] = !fault_in[p];
			end
		end
	end
	// Power-good descriptor times live in software configuration
endmodule
`default_nettype wire

// ===== port_power_pkg.sv
// Types for the port power and overcurrent sense block
package port_power_pkg;
	typedef enum logic [2:0] {
		ST_OFF,
		ST_LOCKOUT,
		ST_HIGH,
		ST_LOW,
		ST_GAP
	} sense_state_t;
endpackage
